/* verilog/sisc_pkg.sv */
// Purpose: constants and carrier types of the standby (idle / stop) controller
// Assumes: 32-bit axi4-lite register slave, one clock
// Notes: byte offsets are word aligned
`default_nettype none
package sisc_pkg;
    localparam logic [7:0] SISC_OFF_MODE = 8'h00;
    localparam logic [7:0] SISC_OFF_CMD = 8'h04;
    localparam logic [7:0] SISC_OFF_CTRL = 8'h08;
    localparam logic [7:0] SISC_OFF_STAT = 8'h0c;
    localparam logic [7:0] SISC_OFF_CFG = 8'h10;
    localparam int SISC_NMI_MASK_BIT = 5;
    localparam int SISC_INT_MASK_BIT = 4;
    localparam int SISC_STB_BIT = 1;
    localparam int SISC_MODE_STOP_BIT = 0;
    localparam int SISC_CFG_OSC_BIT = 0;
    localparam int SISC_CFG_FILT_BIT = 1;
    localparam int SISC_CFG_TBCS_BIT = 2;
    localparam logic [7:0] SISC_CTRL_RST = 8'h00;
    localparam logic [7:0] SISC_CTRL_WMASK = 8'h32;
    localparam logic [1:0] SISC_RESP_OKAY = 2'b00;
    localparam logic [1:0] SISC_RESP_SLVERR = 2'b10;
    localparam int SISC_NUM_EXT = 11;
    localparam int SISC_STAB_SHORT = 16384;
    localparam int SISC_STAB_LONG = 32768;
    localparam int SISC_CNT_W = 20;

    typedef enum logic [1:0] {
        SISC_RUN,
        SISC_IDLE,
        SISC_STOP,
        SISC_STAB
    } sisc_state_t;

    typedef struct packed {
        logic nmi;
        logic [SISC_NUM_EXT-1:0] ext;
        logic nmi_in_service;
        logic lower_than_service;
        logic int_enabled;
    } sisc_wake_t;

    typedef struct packed {
        logic clk_gate_n;
        logic osc_run;
        logic hold_exec;
        logic accept_int;
        logic keep_pending;
        logic resume_next;
    } sisc_ctl_t;
endpackage : sisc_pkg
`default_nettype wire

/* verilog/sisc_wake_qual.sv */
// Purpose: decides whether any wake source qualifies and whether the nmi is one of them
// Assumes: requests are levels synchronous to aclk
// Notes: pure combinational
`default_nettype none
module sisc_wake_qual
    import sisc_pkg::*;
(
    // requests
    input wire sisc_wake_t wake,
    // latched masks and options
    input wire logic nmi_mask,
    input wire logic int_mask,
    input wire logic filt_sel,
    // result
    output logic wake_any,
    output logic nmi_wake
);
    logic [SISC_NUM_EXT-1:0] ext_ok;
    always_comb begin
        ext_ok = wake.ext;
        // inputs 5..10 are the sampled-filter group
        if (filt_sel) begin
            ext_ok[SISC_NUM_EXT-1:5] = '0; // RL6
        end
    end
    assign nmi_wake = wake.nmi & ~nmi_mask; // RL5 RL7 RL22
    assign wake_any = nmi_wake | ((|ext_ok) & ~int_mask); // RL5 RL8
endmodule : sisc_wake_qual
`default_nettype wire

/* verilog/sisc_controller.sv */
// Purpose: idle and software stop sequencing with register slave
// Assumes: axi4-lite master, requests synchronous to aclk
// Notes: reset pin is aresetn itself
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`default_nettype none
// Summary of operation
// RL1 - idle: oscillator runs, system clocks gated
// RL2 - idle exit resumes at once
// RL3 - stores to control registers enter idle
// RL4 - idle holds state, serial slaves may run
// RL5 - wake by nmi, ext 0-4, 20-25, reset
// RL6 - filtered inputs 20-25 cannot wake
// RL7 - wake only if masks were 0
// RL8 - wake regardless of priority
// RL9 - nmi vectors; maskable vectors or continues
// RL10 - lower priority wake stays pending
// RL11 - higher priority wake is accepted
// RL12 - wake inside nmi handler stays pending
// RL13 - nmi wake uses ordinary nmi vector
// RL14 - reset in standby is ordinary reset
// RL15 - stop halts oscillator and all clocks
// RL16 - stores to control registers enter stop
// RL17 - stop exit waits for stabilization count
// RL18 - wait applies to resonator and external clock
// RL19 - stop retains state, serial slaves may run
// RL20 - standby flag set in standby, self clears
// RL21 - control write needs preceding command write
// RL22 - nmi mask bit 5, maskable mask bit 4
// RL23 - mode register selects idle or stop
module sisc_controller
    import sisc_pkg::*;
#(
    parameter int STAB_SHORT = SISC_STAB_SHORT,
    parameter int STAB_LONG = SISC_STAB_LONG
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // wake requests and core status
    input wire sisc_wake_t wake,
    // clock and core control
    output sisc_ctl_t ctl,
    output logic standby_active
);
    typedef struct packed {
        sisc_state_t st;
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [2:0] cfg;
        logic armed;
        logic nmi_m;
        logic int_m;
        logic filt;
        logic [SISC_CNT_W-1:0] cnt;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        sisc_ctl_t ctl;
    } sisc_regs_t;

    localparam logic [SISC_CNT_W-1:0] CNT_SHORT = SISC_CNT_W'(STAB_SHORT - 1);
    localparam logic [SISC_CNT_W-1:0] CNT_LONG = SISC_CNT_W'(STAB_LONG - 1);

    sisc_regs_t r_reg, r_next;
    logic wake_any, nmi_wake;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;

    sisc_wake_qual u_qual (
        .wake(wake),
        .nmi_mask(r_reg.nmi_m),
        .int_mask(r_reg.int_m),
        .filt_sel(r_reg.filt),
        .wake_any(wake_any),
        .nmi_wake(nmi_wake)
    );

    // a frozen slave must not complete handshakes that it cannot record
    assign s_axi_awready = clk_en & ~r_reg.aw_got & ~r_reg.bvalid;
    assign s_axi_wready = clk_en & ~r_reg.w_got & ~r_reg.bvalid;
    assign s_axi_arready = clk_en & ~r_reg.rvalid;
    assign s_axi_bvalid = clk_en & r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_rvalid = clk_en & r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign ctl = r_reg.ctl;
    assign standby_active = r_reg.ctrl[SISC_STB_BIT];
    assign wr_fire = r_reg.aw_got & r_reg.w_got;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign wbyte = r_reg.w_strb[0] ? r_reg.w_data[7:0] : 8'h00;

    always_comb begin
        r_next = r_reg;
        // address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_got = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_got = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.w_strb = s_axi_wstrb;
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (wr_fire) begin
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = SISC_RESP_OKAY;
            // every write other than a command write clears the unlock; reads leave it
            r_next.armed = 1'b0; // RL21
            case (r_reg.aw_addr)
                SISC_OFF_MODE: begin
                    if (r_reg.w_strb[0]) begin
                        r_next.mode = wbyte; // RL23
                    end
                end
                SISC_OFF_CMD: begin
                    r_next.armed = 1'b1; // RL21
                end
                SISC_OFF_CTRL: begin
                    // partial strobes still count as the guarded store when byte 0 is strobed
                    if (r_reg.armed && r_reg.w_strb[0]) begin
                        r_next.ctrl = wbyte & SISC_CTRL_WMASK; // RL21 RL22
                        if (wbyte[SISC_STB_BIT] && r_reg.st == SISC_RUN) begin
                            // masks are frozen at the moment of entry
                            r_next.nmi_m = wbyte[SISC_NMI_MASK_BIT]; // RL7
                            r_next.int_m = wbyte[SISC_INT_MASK_BIT]; // RL7
                            r_next.filt = r_reg.cfg[SISC_CFG_FILT_BIT];
                            if (r_reg.mode[SISC_MODE_STOP_BIT]) begin
                                r_next.st = SISC_STOP; // RL16 RL23
                            end else begin
                                r_next.st = SISC_IDLE; // RL3 RL23
                            end
                        end else begin
                            // only the sequencer may drop the flag while asleep
                            r_next.ctrl[SISC_STB_BIT] = r_reg.ctrl[SISC_STB_BIT]; // RL20
                        end
                    end
                end
                SISC_OFF_CFG: begin
                    if (r_reg.w_strb[0]) begin
                        r_next.cfg = wbyte[2:0];
                    end
                end
                SISC_OFF_STAT: begin
                    r_next.bresp = SISC_RESP_SLVERR;
                end
                default: begin
                    r_next.bresp = SISC_RESP_SLVERR;
                end
            endcase
        end
        if (rd_fire) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = SISC_RESP_OKAY;
            r_next.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                SISC_OFF_MODE: r_next.rdata[7:0] = r_reg.mode;
                SISC_OFF_CMD: r_next.rdata = 32'h0000_0000;
                SISC_OFF_CTRL: r_next.rdata[7:0] = r_reg.ctrl;
                SISC_OFF_STAT: r_next.rdata[1:0] = r_reg.st;
                SISC_OFF_CFG: r_next.rdata[2:0] = r_reg.cfg;
                default: r_next.rresp = SISC_RESP_SLVERR;
            endcase
        end
        // one-cycle handoff hints toward the core
        r_next.ctl.accept_int = 1'b0;
        r_next.ctl.keep_pending = 1'b0;
        r_next.ctl.resume_next = 1'b0;
        case (r_reg.st)
            SISC_RUN: begin
                r_next.ctl.clk_gate_n = 1'b1;
                r_next.ctl.osc_run = 1'b1;
                r_next.ctl.hold_exec = 1'b0;
                if (r_next.st == SISC_IDLE) begin
                    r_next.ctl.clk_gate_n = 1'b0; // RL1 RL4
                end else if (r_next.st == SISC_STOP) begin
                    r_next.ctl.clk_gate_n = 1'b0; // RL15 RL19
                    r_next.ctl.osc_run = 1'b0; // RL15
                end
            end
            SISC_IDLE: begin
                if (wake_any) begin
                    r_next.st = SISC_RUN;
                    r_next.ctl.clk_gate_n = 1'b1; // RL2
                    r_next.ctrl[SISC_STB_BIT] = 1'b0; // RL20
                    r_next = resolve(r_next, nmi_wake);
                end
            end
            SISC_STOP: begin
                if (wake_any) begin
                    r_next.st = SISC_STAB;
                    r_next.ctl.osc_run = 1'b1;
                    r_next.ctl.hold_exec = 1'b1; // RL17
                    // same wait for resonator and external clock
                    r_next.cnt = r_reg.cfg[SISC_CFG_TBCS_BIT] ? CNT_LONG : CNT_SHORT; // RL18
                    r_next.nmi_m = ~nmi_wake;
                end
            end
            SISC_STAB: begin
                if (r_reg.cnt == '0) begin
                    r_next.st = SISC_RUN;
                    r_next.ctl.clk_gate_n = 1'b1; // RL17
                    r_next.ctl.hold_exec = 1'b0;
                    r_next.ctrl[SISC_STB_BIT] = 1'b0; // RL20
                    r_next = resolve(r_next, ~r_reg.nmi_m);
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            default: begin
                r_next.st = SISC_RUN;
            end
        endcase
    end

    // how the core treats the waking request
    function automatic sisc_regs_t resolve(input sisc_regs_t s, input logic by_nmi);
        sisc_regs_t o;
        o = s;
        if (wake.nmi_in_service) begin
            o.ctl.keep_pending = 1'b1; // RL12
        end else if (wake.lower_than_service) begin
            o.ctl.keep_pending = 1'b1; // RL10
        end else if (by_nmi) begin
            o.ctl.accept_int = 1'b1; // RL9 RL11 RL13
        end else if (wake.int_enabled) begin
            o.ctl.accept_int = 1'b1; // RL9 RL11
        end else begin
            o.ctl.resume_next = 1'b1; // RL9
        end
        return o;
    endfunction : resolve

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0; // RL14
            r_reg.st <= SISC_RUN;
            r_reg.ctrl <= SISC_CTRL_RST;
            r_reg.ctl.clk_gate_n <= 1'b1;
            r_reg.ctl.osc_run <= 1'b1;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end
endmodule : sisc_controller
`default_nettype wire

/* bench/sisc_props.sv */
// Purpose: port checks of the standby controller
// Assumes: wake attributes stay steady until serviced
// Notes: bound below
`default_nettype none
module sisc_props
    import sisc_pkg::*;
#(
    parameter int STAB_SHORT = 8,
    parameter int STAB_LONG = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched ports
    input wire sisc_wake_t wake,
    input wire sisc_ctl_t ctl,
    input wire logic standby_active
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic busy;
    logic take_ok;
    logic idle_run;
    logic [2:0] pl;
    assign busy = wake.nmi_in_service | wake.lower_than_service;
    assign pl = {ctl.accept_int, ctl.keep_pending, ctl.resume_next};
    assign take_ok = !busy && (wake.nmi || wake.int_enabled);
    // oscillator up and no wait running: only idle looks like this in standby
    assign idle_run = ctl.osc_run & ~ctl.hold_exec;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // length of the current wait; hold_exec is low in reset
    always_ff @(posedge aclk) begin
        cnt <= ctl.hold_exec ? cnt + 1 : 0;
    end
    a_sleep_gated: assert property (standby_active |-> !ctl.clk_gate_n)
        else $error("clocks run in standby");
    a_stop_dark: assert property (!ctl.osc_run |-> standby_active && !ctl.hold_exec)
        else $error("oscillator off outside stop");
    a_idle_fast: assert property (
        $fell(standby_active) && $past(idle_run) |-> ctl.clk_gate_n)
        else $error("idle exit not immediate");
    a_wait_min: assert property ($fell(ctl.hold_exec) |-> cnt >= STAB_SHORT)
        else $error("wait too short");
    a_wait_max: assert property (ctl.hold_exec |-> cnt < STAB_LONG)
        else $error("wait too long");
    a_wait_gated: assert property (ctl.hold_exec |-> ctl.osc_run && !ctl.clk_gate_n)
        else $error("clocks run during wait");
    a_wake_pulse: assert property (
        $rose(ctl.clk_gate_n) |-> $onehot(pl) && !standby_active ##1 pl == 3'h0)
        else $error("bad wake pulse");
    a_pend_cause: assert property (ctl.keep_pending |-> $past(busy))
        else $error("pending without cause");
    a_take_cause: assert property (
        ctl.accept_int |-> $past(take_ok))
        else $error("accept without cause");
endmodule : sisc_props
bind sisc_controller sisc_props #(.STAB_SHORT(STAB_SHORT), .STAB_LONG(STAB_LONG)) u_props (
    .aclk(aclk), .aresetn(aresetn), .wake(wake), .ctl(ctl), .standby_active(standby_active));
`default_nettype wire

/* bench/sisc_core_model.sv */
// Purpose: core and interrupt sources facing the controller
// Assumes: bench gives a request pattern and a one-cycle fire
// Notes: request held until the outcome pulse
`default_nettype none
module sisc_core_model
    import sisc_pkg::*;
(
    // clock and command
    input wire logic aclk,
    input wire sisc_wake_t req,
    input wire logic fire,
    // controller side
    input wire sisc_ctl_t ctl,
    output sisc_wake_t wake,
    output logic [1:0] outcome
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wake, outcome} = '0;
    // outcome: 1 taken, 2 held pending, 3 next instruction
    always @(posedge aclk) begin
        if (fire) begin
            wake <= req;
            outcome <= 2'h0;
        end else if (ctl.accept_int | ctl.keep_pending | ctl.resume_next) begin
            wake <= '0;
            outcome <= ctl.accept_int ? 2'h1 : (ctl.keep_pending ? 2'h2 : 2'h3);
        end
    end
endmodule : sisc_core_model
`default_nettype wire

/* bench/test_sisc_controller.sv */
// Purpose: self-checking bench of the standby controller
// Assumes: wait counts shortened to 8 and 16
// Notes: wake cases come from one table
`default_nettype none
module test_sisc_controller
    import sisc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, standby_active, fire = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] bresp, rresp, outcome;
    sisc_wake_t wake, req = '0;
    sisc_ctl_t ctl;
    int err_count = 0, total_checks = 0;
    // wake, cfg, mode, ctrl, outcome (0 = must stay asleep)
    localparam logic [28:0] CASES [13] = '{
        {15'h4000, 3'h0, 1'b0, 8'h02, 2'h1}, {15'h0009, 3'h0, 1'b0, 8'h02, 2'h1},
        {15'h0008, 3'h0, 1'b0, 8'h02, 2'h3}, {15'h2003, 3'h0, 1'b0, 8'h02, 2'h2},
        {15'h4004, 3'h0, 1'b0, 8'h02, 2'h2}, {15'h4000, 3'h0, 1'b0, 8'h12, 2'h1},
        {15'h0009, 3'h0, 1'b0, 8'h22, 2'h1}, {15'h4000, 3'h0, 1'b0, 8'h22, 2'h0},
        {15'h0009, 3'h0, 1'b0, 8'h32, 2'h0}, {15'h4000, 3'h0, 1'b1, 8'h02, 2'h1},
        {15'h0081, 3'h5, 1'b1, 8'h02, 2'h1}, {15'h0101, 3'h2, 1'b1, 8'h02, 2'h0},
        {15'h0008, 3'h2, 1'b0, 8'h02, 2'h3}
    };
    always #2.5 aclk = ~aclk;
    sisc_controller #(.STAB_SHORT(8), .STAB_LONG(16)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wake(wake), .ctl(ctl), .standby_active(standby_active));
    sisc_core_model core_u (
        .aclk(aclk), .req(req), .fire(fire), .ctl(ctl), .wake(wake), .outcome(outcome));
    task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // each channel is held until its own ready is sampled high at a rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_open, w_open;
        @(posedge aclk);
        aw_open = 1'b1;
        w_open = 1'b1;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (aw_open && awready) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && wready) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        chk("bresp", er, bresp);
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk("rdata", {e, 2'b00}, {rdata, rresp});
        rready <= 1'b0;
    endtask : axi_rd
    task automatic run_case(input logic [28:0] c);
        int n;
        int w;
        n = 0;
        w = c[13] ? 16 : 8;
        axi_wr(SISC_OFF_CFG, {29'h0, c[13:11]}, SISC_RESP_OKAY);
        axi_wr(SISC_OFF_MODE, {31'h0, c[10]}, SISC_RESP_OKAY);
        // masks go in before the standby bit
        for (int k = 0; k < 2; k++) begin
            axi_wr(SISC_OFF_CMD, 32'h0, SISC_RESP_OKAY);
            axi_wr(SISC_OFF_CTRL, {24'h0, c[9:2] & (k ? 8'hff : 8'h30)}, 2'b00);
        end
        chk("sleep", {2'b10, c[10]}, {standby_active, ctl.clk_gate_n, !ctl.osc_run});
        axi_rd(SISC_OFF_CTRL, {24'h0, c[9:2]});
        axi_rd(SISC_OFF_STAT, {30'h0, c[10], !c[10]});
        req <= c[28:14];
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        if (c[1:0] == 2'h0) begin
            repeat (40) @(posedge aclk);
            chk("asleep", 3'h4, {standby_active, outcome});
            req <= '0;
            {aresetn, fire} <= 2'b01;
            repeat (5) @(posedge aclk);
            {aresetn, fire} <= 2'b10;
            @(negedge aclk);
            chk("reset", 7'h60, {ctl, standby_active});
        end else begin
            do begin
                @(negedge aclk);
                n++;
            end while (outcome == 2'h0);
            chk("outcome", c[1:0], outcome);
            chk("awake", 2'b10, {ctl.clk_gate_n, standby_active});
            chk("delay", 1, c[10] ? (n >= w && n <= w + 5) : n <= 5);
        end
    endtask : run_case
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(SISC_OFF_CTRL, 32'h0);
        chk("ctl", 6'h30, ctl);
        // a frozen block offers no handshake
        clk_en <= 1'b0;
        @(posedge aclk);
        chk("frozen", 3'h0, {awready, wready, arready});
        clk_en <= 1'b1;
        axi_wr(SISC_OFF_STAT, 32'h1, SISC_RESP_SLVERR);
        axi_wr(8'h40, 32'h1, SISC_RESP_SLVERR);
        axi_wr(SISC_OFF_CTRL, 32'h2, SISC_RESP_OKAY);
        axi_wr(SISC_OFF_CMD, 32'h0, SISC_RESP_OKAY);
        axi_wr(SISC_OFF_MODE, 32'h1, SISC_RESP_OKAY);
        axi_wr(SISC_OFF_CTRL, 32'h2, SISC_RESP_OKAY);
        axi_rd(SISC_OFF_CTRL, 32'h0);
        axi_rd(SISC_OFF_MODE, 32'h1);
        foreach (CASES[i])
            run_case(CASES[i]);
        print_verdict();
    end
endmodule : test_sisc_controller
`default_nettype wire
